// file: hw/bdgw_pkg.sv
// shared constants and carrier types for the bridge window base registers
`default_nettype none
package bdgw_pkg;
    ////////////////////////////////////////////////////////////////////////
    // register offsets as seen from the primary interface
    localparam logic [7:0] BDGW_OFF_PRI_CTL = 8'h14; // primary_ctl_io_window
    localparam logic [7:0] BDGW_OFF_DS_FWD = 8'h18; // downstream_forward_window
    localparam logic [7:0] BDGW_OFF_SEC_CTL = 8'h54; // secondary_ctl_io_window
    localparam logic [7:0] BDGW_OFF_US_FWD = 8'h58; // upstream_forward_window
    // the secondary side sees the two halves swapped, one address bit apart
    localparam logic [7:0] BDGW_SIDE_SWAP = 8'h40;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int BDGW_CTL_BASE_LSB = 8; // control window base bits 31:8
    localparam int BDGW_FWD_BASE_LSB = 6; // forward window base bits 31:6
    localparam int BDGW_MEM_MIN_LSB = 12; // memory window is at least 4 KB
    localparam int BDGW_SETUP_EN_BIT = 31; // setup: window enable
    localparam int BDGW_SETUP_IO_BIT = 0; // setup: 1 requests i/o space
    localparam int BDGW_SETUP_TYPE_LSB = 1; // setup: memory type, 2 bits
    localparam int BDGW_SETUP_PF_BIT = 3; // setup: prefetchable memory
    localparam int BDGW_CTL_BASE_W = 32 - BDGW_CTL_BASE_LSB;
    localparam int BDGW_FWD_BASE_W = 32 - BDGW_FWD_BASE_LSB;
    localparam int BDGW_MEM_CLR_W = BDGW_MEM_MIN_LSB - BDGW_FWD_BASE_LSB;

    ////////////////////////////////////////////////////////////////////////
    // values after reset
    localparam logic [31:0] BDGW_DATA_RST = 32'h0000_0000;
    localparam logic [BDGW_CTL_BASE_W-1:0] BDGW_CTL_BASE_RST = 24'h00_0000;
    localparam logic [BDGW_FWD_BASE_W-1:0] BDGW_FWD_BASE_RST = 26'h000_0000;
    localparam logic BDGW_SIDE_PRI = 1'b0; // access from primary interface

    ////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic valid; // one-cycle request strobe
        logic side; // 0 primary interface, 1 secondary interface
        logic write; // 1 write, 0 read
        logic [7:0] addr; // configuration byte offset, low two bits ignored
        logic [3:0] be; // byte enables, active high
        logic [31:0] wdata; // write data
    } bdgw_cfg_req_t;

    typedef struct packed {
        logic ack; // one-cycle answer strobe
        logic hit; // offset belongs to this block
        logic [31:0] rdata; // read data, zero on a write or a miss
    } bdgw_cfg_rsp_t;

    typedef struct packed {
        logic valid; // transaction address phase on a bus
        logic is_io; // 1 i/o command, 0 memory command
        logic [31:0] addr; // transaction address
    } bdgw_txn_t;

    typedef enum logic {BDGW_ST_IDLE, BDGW_ST_ANSWER} bdgw_state_t;
endpackage
`default_nettype wire

// file: hw/bdgw_ctl_bar.sv
// fixed 256-byte i/o window onto the bridge's own control registers
`default_nettype none
module bdgw_ctl_bar
    import bdgw_pkg::*;
(
    input wire logic core_clk, // bridge clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic wr_en, // write strobe to this register
    input wire logic [3:0] be, // byte enables
    input wire logic [31:0] wdata, // write data
    output logic [31:0] rd_value, // value returned on a read
    output logic [BDGW_CTL_BASE_W-1:0] base // programmed base, bits 31:8
);
    logic [BDGW_CTL_BASE_W-1:0] base_ff; // writable base bits
    logic [BDGW_CTL_BASE_W-1:0] nxt_base; // next base value
    wire logic [31:0] be_mask; // byte enables spread to bits

    ////////////////////////////////////////////////////////////////////////
    // byte-lane write of bits 31:8, low lane has nothing writable
    assign be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    assign nxt_base = wr_en ?
        ((base_ff & ~be_mask[31:BDGW_CTL_BASE_LSB]) |
         (wdata[31:BDGW_CTL_BASE_LSB] & be_mask[31:BDGW_CTL_BASE_LSB])) :
        base_ff;

    // base register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            base_ff <= BDGW_CTL_BASE_RST;
        end else begin
            base_ff <= nxt_base;
        end
    end

    // i/o space flag, reserved zeros, then the base
    assign rd_value = {base_ff, 7'h00, 1'b1};
    assign base = base_ff;
endmodule
`default_nettype wire

// file: hw/bdgw_fwd_bar.sv
// forwarding window base register shaped by its setup register
`default_nettype none
module bdgw_fwd_bar
    import bdgw_pkg::*;
(
    input wire logic core_clk, // bridge clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic [31:0] setup, // companion setup register
    input wire logic wr_en, // write strobe to this register
    input wire logic [3:0] be, // byte enables
    input wire logic [31:0] wdata, // write data
    output logic [31:0] rd_value, // value returned on a read
    output logic [BDGW_FWD_BASE_W-1:0] cmp_mask, // decoded bits 31:6
    output logic [BDGW_FWD_BASE_W-1:0] base, // visible base bits 31:6
    output logic enabled, // window enabled by setup
    output logic is_io // window claims i/o space
);
    logic [BDGW_FWD_BASE_W-1:0] base_ff; // stored base bits
    logic [BDGW_FWD_BASE_W-1:0] nxt_base; // next base value
    wire logic [31:0] be_mask; // byte enables spread to bits
    wire logic [BDGW_FWD_BASE_W-1:0] size_mask; // writable bits by setup
    wire logic [BDGW_FWD_BASE_W-1:0] wr_bits; // bits written this cycle
    wire logic [1:0] mem_type; // memory type field
    wire logic mem_pf; // prefetchable memory

    ////////////////////////////////////////////////////////////////////////
    // setup decides enable, space, size
    assign enabled = setup[BDGW_SETUP_EN_BIT];
    assign is_io = setup[BDGW_SETUP_IO_BIT];
    // bit 31 always writable so 2 GB is the ceiling; memory drops 11:6
    assign size_mask = {1'b1, setup[30:BDGW_FWD_BASE_LSB]} &
        {{(BDGW_FWD_BASE_W-BDGW_MEM_CLR_W){1'b1}},
         {BDGW_MEM_CLR_W{is_io}}};
    assign be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    assign wr_bits = (wr_en && enabled) ?
        (be_mask[31:BDGW_FWD_BASE_LSB] & size_mask) : '0;
    assign nxt_base = (base_ff & ~wr_bits) |
        (wdata[31:BDGW_FWD_BASE_LSB] & wr_bits);

    // base register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            base_ff <= BDGW_FWD_BASE_RST;
        end else begin
            base_ff <= nxt_base;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read view: all zeros while disabled
    assign mem_type = is_io ? 2'h0 : setup[BDGW_SETUP_TYPE_LSB+:2];
    assign mem_pf = !is_io && setup[BDGW_SETUP_PF_BIT];
    assign base = base_ff & size_mask;
    assign cmp_mask = size_mask;
    assign rd_value = enabled ?
        {base, 2'h0, mem_pf, mem_type, is_io} :
        BDGW_DATA_RST;
endmodule
`default_nettype wire

// file: hw/bdgw_top.sv
// window base registers of the bridge: control i/o windows and forwarding windows
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Operation
// - control window bit 0 reads one
// - control window bits 7:1 read zero
// - control window bits 31:8 hold base
// - primary/secondary control windows decode their own bus
// - forward windows claim hits downstream or upstream
// - forward windows disabled, zero after reset
// - i/o 64-256 bytes, memory 4 KB-2 GB; i/o size is not capped at 256 bytes here, setup can open it up to 2 GB
// - size and type come from setup register
// - forward bit 0 marks i/o space
// - forward bits 2:1 give memory type
// - forward bit 3 marks prefetchable memory
// - forward bits 5:4 read zero
// - base bits writable only where setup set
// - setup bit 31 zero disables window
// - at least 64 B i/o, 4 KB memory
module bdgw_top
    import bdgw_pkg::*;
(
    input wire logic core_clk, // bridge clock, 40 MHz
    input wire logic rst_n, // synchronous reset, active low
    input wire bdgw_cfg_req_t cfg_req, // configuration access request
    input wire logic [31:0] ds_setup, // downstream window setup value
    input wire logic [31:0] us_setup, // upstream window setup value
    input wire bdgw_txn_t pri_txn, // transaction seen on primary bus
    input wire bdgw_txn_t sec_txn, // transaction seen on secondary bus
    output bdgw_cfg_rsp_t cfg_rsp_ff, // configuration answer
    output logic cfg_ready_ff, // high while a request may be taken
    output logic pri_csr_hit_ff, // primary i/o hits control window
    output logic sec_csr_hit_ff, // secondary i/o hits control window
    output logic ds_fwd_hit_ff, // primary access to forward downstream
    output logic us_fwd_hit_ff, // secondary access to forward upstream
    output logic ds_fwd_en_ff, // downstream window enabled
    output logic us_fwd_en_ff // upstream window enabled
);

    ////////////////////////////////////////////////////////////////////////////
    // access sequencing
    bdgw_state_t state_ff; // access state
    bdgw_state_t nxt_state; // next access state
    bdgw_cfg_rsp_t nxt_rsp; // answer being formed

    // a strobe in the answer cycle is dropped
    wire logic req_take; // request accepted this cycle
    assign req_take = cfg_req.valid && (state_ff == BDGW_ST_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // offset decode, secondary side folded onto primary view
    wire logic [7:0] eff_off; // offset as the primary side would see it
    wire logic sel_pri_ctl; // primary control window selected
    wire logic sel_sec_ctl; // secondary control window selected
    wire logic sel_ds_fwd; // downstream forward window selected
    wire logic sel_us_fwd; // upstream forward window selected
    wire logic any_sel; // offset belongs to this block

    // one physical copy per register, only the address view swaps
    assign eff_off = {cfg_req.addr[7:2], 2'b00} ^
        ((cfg_req.side == BDGW_SIDE_PRI) ? 8'h00 : BDGW_SIDE_SWAP);
    assign sel_pri_ctl = (eff_off == BDGW_OFF_PRI_CTL);
    assign sel_sec_ctl = (eff_off == BDGW_OFF_SEC_CTL);
    assign sel_ds_fwd = (eff_off == BDGW_OFF_DS_FWD);
    assign sel_us_fwd = (eff_off == BDGW_OFF_US_FWD);
    assign any_sel = sel_pri_ctl || sel_sec_ctl || sel_ds_fwd || sel_us_fwd;

    ////////////////////////////////////////////////////////////////////////////
    // write strobes per register
    wire logic wr_take; // accepted write
    wire logic [1:0] ctl_wr; // control window writes, 0 primary 1 secondary
    wire logic [1:0] fwd_wr; // forward window writes, 0 down 1 up
    assign wr_take = req_take && cfg_req.write;
    assign ctl_wr = {wr_take && sel_sec_ctl, wr_take && sel_pri_ctl};
    assign fwd_wr = {wr_take && sel_us_fwd, wr_take && sel_ds_fwd};

    ////////////////////////////////////////////////////////////////////////////
    // register instances; index 0 faces primary, index 1 secondary
    wire logic [31:0] ctl_rd [2]; // control window read values
    wire logic [BDGW_CTL_BASE_W-1:0] ctl_base [2]; // control window bases
    wire logic [31:0] fwd_rd [2]; // forward window read values
    wire logic [BDGW_FWD_BASE_W-1:0] fwd_mask [2]; // forward compare masks
    wire logic [BDGW_FWD_BASE_W-1:0] fwd_base [2]; // forward bases
    wire logic [1:0] fwd_en; // forward windows enabled
    wire logic [1:0] fwd_io; // forward windows claim i/o
    wire logic [31:0] fwd_setup [2]; // setup per forward window
    wire bdgw_txn_t txn [2]; // bus activity per side
    wire logic [1:0] ctl_hit; // control window address matches
    wire logic [1:0] fwd_hit; // forward window address matches

    assign fwd_setup[0] = ds_setup;
    assign fwd_setup[1] = us_setup;
    assign txn[0] = pri_txn;
    assign txn[1] = sec_txn;

    genvar gi;
        for (gi = 0; gi < 2; gi++) begin : g_win
            // fixed 256-byte window onto the control registers
            bdgw_ctl_bar u_ctl (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .wr_en(ctl_wr[gi]),
                .be(cfg_req.be),
                .wdata(cfg_req.wdata),
                .rd_value(ctl_rd[gi]),
                .base(ctl_base[gi])
            );

            // forwarding window shaped by its setup value
            bdgw_fwd_bar u_fwd (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .setup(fwd_setup[gi]),
                .wr_en(fwd_wr[gi]),
                .be(cfg_req.be),
                .wdata(cfg_req.wdata),
                .rd_value(fwd_rd[gi]),
                .cmp_mask(fwd_mask[gi]),
                .base(fwd_base[gi]),
                .enabled(fwd_en[gi]),
                .is_io(fwd_io[gi])
            );

            // control window claims i/o accesses of its own bus only
            assign ctl_hit[gi] = txn[gi].valid && txn[gi].is_io &&
                (txn[gi].addr[31:BDGW_CTL_BASE_LSB] == ctl_base[gi]);

            // match on decoded bits, in the window's own space
            assign fwd_hit[gi] = txn[gi].valid && fwd_en[gi] &&
                (txn[gi].is_io == fwd_io[gi]) &&
                ((txn[gi].addr[31:BDGW_FWD_BASE_LSB] & fwd_mask[gi]) ==
                 fwd_base[gi]);
        end

    ////////////////////////////////////////////////////////////////////////////
    // read data select, sampled before the write lands
    wire logic [31:0] rd_sel; // read value of the selected register
    assign rd_sel = sel_pri_ctl ? ctl_rd[0] :
        sel_sec_ctl ? ctl_rd[1] :
        sel_ds_fwd ? fwd_rd[0] :
        sel_us_fwd ? fwd_rd[1] :
        BDGW_DATA_RST;

    // answer content for the next cycle
    always_comb begin
        nxt_rsp.ack = req_take;
        nxt_rsp.hit = req_take && any_sel;
        // writes and misses answer zero so the bus mux stays quiet
        nxt_rsp.rdata = (req_take && !cfg_req.write) ? rd_sel : BDGW_DATA_RST;
    end

    // state transition: one answer cycle after every accepted request
    always_comb begin
        case (state_ff)
            BDGW_ST_IDLE: begin
                nxt_state = req_take ? BDGW_ST_ANSWER : BDGW_ST_IDLE;
            end
            BDGW_ST_ANSWER: begin
                nxt_state = BDGW_ST_IDLE;
            end
            default: begin
                nxt_state = BDGW_ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // access state and answer registers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_ff <= BDGW_ST_IDLE;
            cfg_rsp_ff <= '0;
            cfg_ready_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cfg_rsp_ff <= nxt_rsp;
            cfg_ready_ff <= (nxt_state == BDGW_ST_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decode outputs, one cycle behind the bus address phase
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pri_csr_hit_ff <= 1'b0;
            sec_csr_hit_ff <= 1'b0;
            ds_fwd_hit_ff <= 1'b0;
            us_fwd_hit_ff <= 1'b0;
        end else begin
            pri_csr_hit_ff <= ctl_hit[0];
            sec_csr_hit_ff <= ctl_hit[1];
            ds_fwd_hit_ff <= fwd_hit[0];
            us_fwd_hit_ff <= fwd_hit[1];
        end
    end

    // enable state follows the setup value; the local cpu must settle setup
    // before letting the host in, there is no guard against a size change
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ds_fwd_en_ff <= 1'b0;
            us_fwd_en_ff <= 1'b0;
        end else begin
            ds_fwd_en_ff <= fwd_en[0];
            us_fwd_en_ff <= fwd_en[1];
        end
    end
endmodule
`default_nettype wire

// file: testbench/bdgw_top_props.sv
// concurrent checks at the top ports
`default_nettype none
module bdgw_top_props
    import bdgw_pkg::*;
(
    input wire logic core_clk, // clock
    input wire logic rst_n, // reset, active low
    input wire bdgw_cfg_req_t cfg_req, // request
    input wire logic [31:0] ds_setup, // downstream setup
    input wire logic [31:0] us_setup, // upstream setup
    input wire bdgw_txn_t pri_txn, // primary bus
    input wire bdgw_txn_t sec_txn, // secondary bus
    input wire bdgw_cfg_rsp_t cfg_rsp_ff, // answer
    input wire logic cfg_ready_ff, // may take
    input wire logic pri_csr_hit_ff, // primary ctl hit
    input wire logic sec_csr_hit_ff, // secondary ctl hit
    input wire logic ds_fwd_hit_ff, // downstream hit
    input wire logic us_fwd_hit_ff, // upstream hit
    input wire logic us_fwd_en_ff // upstream on
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    // request decode
    wire logic take = cfg_req.valid && !cfg_rsp_ff.ack; // idle and asked
    wire logic rd_take = take && !cfg_req.write; // read taken
    wire logic is_ctl = {cfg_req.addr[7], cfg_req.addr[5:2]} == 5'h05; // 0x14 or 0x54
    wire logic is_fwd = {cfg_req.addr[7], cfg_req.addr[5:2]} == 5'h06; // 0x18 or 0x58
    wire logic to_us = cfg_req.side ^ cfg_req.addr[6]; // swapped view
    wire logic [31:0] sel_setup = to_us ? us_setup : ds_setup; // setup behind it
    logic [31:0] setup_q; // setup seen at the taking edge
    wire logic [5:0] low_exp = !setup_q[31] ? 6'h00 : setup_q[0] ? 6'h01 : {2'b00, setup_q[3:1], 1'b0};
    // setup at the taking edge
    always_ff @(posedge core_clk) begin
        setup_q <= sel_setup;
    end
    ////////////////////////////////////////////////////////////////////////
    property p_answer; take |=> cfg_rsp_ff.ack; endproperty
    a_answer: assert property (p_answer) else $error("request not answered");
    property p_single; cfg_rsp_ff.ack |-> !cfg_ready_ff ##1 !cfg_rsp_ff.ack; endproperty
    a_single: assert property (p_single) else $error("answer longer than one cycle");
    property p_quiet; !cfg_rsp_ff.ack |-> cfg_rsp_ff.rdata == 32'h0; endproperty
    a_quiet: assert property (p_quiet) else $error("read data outside answer");
    property p_ctl_low; rd_take && is_ctl |=> cfg_rsp_ff.hit && cfg_rsp_ff.rdata[7:0] == 8'h01; endproperty
    a_ctl_low: assert property (p_ctl_low) else $error("control low byte wrong");
    property p_fwd_low; rd_take && is_fwd |=> cfg_rsp_ff.rdata[5:0] == low_exp; endproperty
    a_fwd_low: assert property (p_fwd_low) else $error("forward low bits wrong");
    property p_fwd_off; rd_take && is_fwd && !sel_setup[31] |=> cfg_rsp_ff.rdata == 32'h0; endproperty
    a_fwd_off: assert property (p_fwd_off) else $error("disabled window not zero");
    property p_io_only; !(sec_txn.valid && sec_txn.is_io) |=> !sec_csr_hit_ff; endproperty
    a_io_only: assert property (p_io_only) else $error("control hit without i/o");
    property p_cause; !pri_txn.valid |=> !pri_csr_hit_ff && !ds_fwd_hit_ff; endproperty
    a_cause: assert property (p_cause) else $error("hit without transaction");
    property p_dis; !(sec_txn.valid && (us_setup[31] || us_fwd_en_ff)) |=> !us_fwd_hit_ff; endproperty
    a_dis: assert property (p_dis) else $error("disabled window hit");
endmodule
bind bdgw_top bdgw_top_props bdgw_top_props_inst (.core_clk(core_clk), .rst_n(rst_n),
    .cfg_req(cfg_req), .ds_setup(ds_setup), .us_setup(us_setup), .pri_txn(pri_txn),
    .sec_txn(sec_txn), .cfg_rsp_ff(cfg_rsp_ff), .cfg_ready_ff(cfg_ready_ff),
    .pri_csr_hit_ff(pri_csr_hit_ff), .sec_csr_hit_ff(sec_csr_hit_ff),
    .ds_fwd_hit_ff(ds_fwd_hit_ff), .us_fwd_hit_ff(us_fwd_hit_ff),
    .us_fwd_en_ff(us_fwd_en_ff));
`default_nettype wire

// file: testbench/bdgw_setup_src.sv
// setup source standing in for the local processor
`default_nettype none
module bdgw_setup_src (
    input wire logic core_clk, // clock
    input wire logic rst_n, // reset, active low
    input wire logic load, // one-cycle load strobe
    input wire logic [31:0] ds_val, // downstream value to load
    input wire logic [31:0] us_val, // upstream value to load
    output logic [31:0] ds_setup, // downstream setup
    output logic [31:0] us_setup, // upstream setup
    output logic host_open // host may now reach the windows
);
    timeunit 1ns;
    timeprecision 1ps;
    // both setups load together, so the host never sees half a size
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ds_setup <= 32'h0; // windows start disabled
            us_setup <= 32'h0;
            host_open <= 1'b0;
        end else if (load) begin
            ds_setup <= ds_val; // size and type come from here
            us_setup <= us_val;
            host_open <= 1'b1; // opened on the same edge as the load lands
        end
    end
endmodule
`default_nettype wire

// file: testbench/bdgw_top_bench.sv
// self-checking bench for the bridge window base registers
`default_nettype none
module bdgw_top_bench import bdgw_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0; // 40 MHz clock
    logic rst_n = 1'b0; // reset, active low
    bdgw_cfg_req_t cfg_req = '0; // configuration request
    bdgw_txn_t pri_txn = '0; // primary transaction
    bdgw_txn_t sec_txn = '0; // secondary transaction
    logic load = 1'b0; // setup load strobe
    logic [31:0] ds_val = 32'h0, us_val = 32'h0; // setups to load
    logic [31:0] ds_setup, us_setup; // setups in force
    logic host_open; // host access allowed
    bdgw_cfg_rsp_t cfg_rsp_ff; // answer
    logic cfg_ready_ff, pri_csr_hit_ff, sec_csr_hit_ff, ds_fwd_hit_ff, us_fwd_hit_ff;
    logic ds_fwd_en_ff, us_fwd_en_ff; // enable copies
    int err_total = 0; // mismatches
    int tests_run = 0; // comparisons
    int seed = 32'h5347; // random seed
    logic [32:0] exp_q[$]; // notes {hit, rdata}, oldest first

    bdgw_top bdgw_top_inst (.core_clk(core_clk), .rst_n(rst_n), .cfg_req(cfg_req),
        .ds_setup(ds_setup), .us_setup(us_setup), .pri_txn(pri_txn), .sec_txn(sec_txn),
        .cfg_rsp_ff(cfg_rsp_ff), .cfg_ready_ff(cfg_ready_ff), .pri_csr_hit_ff(pri_csr_hit_ff),
        .sec_csr_hit_ff(sec_csr_hit_ff), .ds_fwd_hit_ff(ds_fwd_hit_ff),
        .us_fwd_hit_ff(us_fwd_hit_ff), .ds_fwd_en_ff(ds_fwd_en_ff), .us_fwd_en_ff(us_fwd_en_ff));
    bdgw_setup_src bdgw_setup_src_inst (.core_clk(core_clk), .rst_n(rst_n), .load(load),
        .ds_val(ds_val), .us_val(us_val), .ds_setup(ds_setup), .us_setup(us_setup),
        .host_open(host_open));

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    // comparison and closing
    task automatic compare_word(input logic [32:0] got, input logic [32:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic compare_bit(input logic got, input logic exp);
        compare_word({32'h0, got}, {32'h0, exp});
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // match each answer to the oldest note
    initial begin
        forever begin
            @(posedge core_clk);
            #1;
            if (cfg_rsp_ff.ack === 1'b1) begin
                if (exp_q.size() == 0)
                    compare_bit(cfg_rsp_ff.ack, 1'b0);
                else
                    compare_word({cfg_rsp_ff.hit, cfg_rsp_ff.rdata}, exp_q.pop_front());
            end
        end
    end
    // a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        results();
    end
    ////////////////////////////////////////////////////////////////////////
    // one request, then an idle answer cycle
    task automatic cfg(input logic sd, input logic wr, input logic [7:0] a,
        input logic [3:0] be, input logic [31:0] wd, input logic [32:0] exp);
        @(posedge core_clk);
        cfg_req <= '{1'b1, sd, wr, a, be, wd};
        exp_q.push_back(exp);
        @(posedge core_clk);
        cfg_req.valid <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic sd, input logic [7:0] a, input logic [31:0] exp);
        cfg(sd, 1'b0, a, 4'hF, 32'h0, {1'b1, exp});
    endtask
    task automatic wr(input logic sd, input logic [7:0] a, input logic [3:0] be,
        input logic [31:0] wd);
        cfg(sd, 1'b1, a, be, wd, {1'b1, 32'h0});
    endtask
    task automatic set_up(input logic [31:0] d, input logic [31:0] u);
        @(posedge core_clk);
        ds_val <= d;
        us_val <= u;
        load <= 1'b1;
        @(posedge core_clk);
        load <= 1'b0;
    endtask
    task automatic txn(input logic pri, input logic io, input logic [31:0] a,
        input logic e_csr, input logic e_fwd);
        @(posedge core_clk);
        if (pri)
            pri_txn <= '{1'b1, io, a};
        else
            sec_txn <= '{1'b1, io, a};
        @(posedge core_clk);
        pri_txn.valid <= 1'b0;
        sec_txn.valid <= 1'b0;
        #1;
        compare_bit(pri ? pri_csr_hit_ff : sec_csr_hit_ff, e_csr);
        compare_bit(pri ? ds_fwd_hit_ff : us_fwd_hit_ff, e_fwd);
    endtask
    // expected forward window read value
    function automatic logic [31:0] fwd_exp(input logic [31:0] s, input logic [31:0] w);
        logic [25:0] m;
        m = {1'b1, s[30:12], s[11:6] & {6{s[0]}}};
        fwd_exp = s[31] ? {w[31:6] & m, 2'b00, s[0] ? 3'b000 : s[3:1], s[0]} : 32'h0;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] w;
        logic [31:0] cases [9] = '{32'hFFFF_FFC1, 32'hFFFF_FF81, 32'hFFFF_FF01, 32'hFFFF_F00C,
            32'hFFFF_F002, 32'h8000_0000, 32'hFFFF_FFC0, 32'hFFFF_FFCF, 32'h7FFF_FFC1};
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        set_up(32'h0, 32'h0);
        for (int i = 0; i < 8 && host_open !== 1'b1; i++) @(posedge core_clk);
        compare_bit(host_open, 1'b1);
        for (int s = 0; s < 2; s++) begin
            rd(s[0], 8'h14, 32'h1);
            rd(s[0], 8'h54, 32'h1);
            rd(s[0], 8'h18, 32'h0);
            rd(s[0], 8'h58, 32'h0);
        end
        cfg(1'b0, 1'b0, 8'h20, 4'hF, 32'h0, 33'h0);
        wr(1'b0, 8'h18, 4'hF, 32'hFFFF_FFFF);
        set_up(32'hFFFF_FFC1, 32'h0);
        rd(1'b0, 8'h18, 32'h0000_0001);
        $display("test reset done");
        for (int s = 0; s < 2; s++) begin
            w = $random(seed);
            wr(s[0], 8'h14, 4'hF, w);
            rd(s[0], 8'h14, {w[31:8], 8'h01});
            rd(!s[0], 8'h54, {w[31:8], 8'h01});
            wr(s[0], 8'h14, 4'h3, ~w);
            rd(s[0], 8'h14, {w[31:16], ~w[15:8], 8'h01});
        end
        $display("test control windows done");
        for (int i = 0; i < 9; i++) begin
            set_up(cases[i], cases[i]);
            w = $random(seed);
            wr(1'b0, 8'h18, 4'hF, w);
            rd(1'b0, 8'h18, fwd_exp(cases[i], w));
            w = $random(seed);
            wr(1'b1, 8'h18, 4'hF, w);
            rd(1'b0, 8'h58, fwd_exp(cases[i], w));
        end
        @(posedge core_clk);
        cfg_req <= '{1'b1, 1'b0, 1'b0, 8'h18, 4'hF, 32'h0};
        exp_q.push_back(33'h1_0000_0000);
        @(posedge core_clk);
        cfg_req.addr <= 8'h20;
        @(posedge core_clk);
        cfg_req.valid <= 1'b0;
        repeat (2) @(posedge core_clk);
        $display("test forward windows done");
        set_up(32'hFFFF_FFC1, 32'hFFFF_F000);
        wr(1'b0, 8'h14, 4'hF, 32'h00AB_CD00);
        wr(1'b0, 8'h54, 4'hF, 32'h0012_3400);
        wr(1'b0, 8'h18, 4'hF, 32'h0000_1040);
        wr(1'b0, 8'h58, 4'hF, 32'h8000_0000);
        compare_bit(ds_fwd_en_ff, 1'b1);
        compare_bit(us_fwd_en_ff, 1'b1);
        txn(1'b1, 1'b1, 32'h00AB_CD7F, 1'b1, 1'b0);
        txn(1'b1, 1'b0, 32'h00AB_CD7F, 1'b0, 1'b0);
        txn(1'b0, 1'b1, 32'h0012_3404, 1'b1, 1'b0);
        txn(1'b1, 1'b1, 32'h0000_107C, 1'b0, 1'b1);
        txn(1'b1, 1'b1, 32'h0000_1080, 1'b0, 1'b0);
        txn(1'b0, 1'b0, 32'h8000_0FFC, 1'b0, 1'b1);
        txn(1'b0, 1'b1, 32'h8000_0010, 1'b0, 1'b0);
        $display("test decode done");
        repeat (4) @(posedge core_clk);
        compare_bit(exp_q.size() == 0, 1'b1);
        results();
    end
endmodule
`default_nettype wire
